// ===== logic/eee_pkg.sv
// Constants for the per-port EEE control block and its indirect access path
`default_nettype none
package eee_pkg;
  // APB word indexes of the access bytes; byte address is four times the index
  localparam logic [7:0]  IDX_ACC_CTRL  = 8'h6E;
  localparam logic [7:0]  IDX_ACC_OFFS  = 8'h6F;
  localparam logic [7:0]  IDX_ACC_DATA  = 8'hA0;
  // Access control byte layout
  localparam logic [2:0]  SEL_EEE       = 3'h1;
  localparam int          SEL_MSB       = 7;
  localparam int          SEL_LSB       = 5;
  localparam int          DIR_READ_BIT  = 4;
  localparam logic [3:0]  PORT_GLOBAL   = 4'h0;
  localparam logic [3:0]  PORT_FIRST    = 4'h3;
  localparam logic [3:0]  PORT_SECOND   = 4'h4;
  // Indirect byte offsets
  localparam logic [7:0]  OFS_CTL_HI    = 8'h2C;
  localparam logic [7:0]  OFS_CTL_LO    = 8'h2D;
  localparam logic [7:0]  OFS_WAIT_HI   = 8'h2E;
  localparam logic [7:0]  OFS_WAIT_LO   = 8'h2F;
  // Bit positions inside the bytes of the control/status register
  localparam int          POS_TEN_OFF   = 7;
  localparam int          POS_HW_EXCH   = 7;
  localparam int          POS_HW_FAST   = 6;
  localparam int          POS_TX_STICKY = 5;
  localparam int          POS_TX_NOW    = 4;
  localparam int          POS_RX_STICKY = 3;
  localparam int          POS_RX_NOW    = 2;
  localparam int          POS_SW_SEL    = 1;
  localparam int          POS_FAST_EN   = 0;
  // Values after reset
  localparam logic        RST_TEN_OFF   = 1'b1;
  localparam logic        RST_HW_EXCH   = 1'b1;
  localparam logic        RST_SW_SEL    = 1'b0;
  localparam logic        RST_FAST_EN   = 1'b0;
  localparam logic [7:0]  RST_WAIT_CNT  = 8'h27;
  // Wake wait timing
  localparam int          CLK_PERIOD_PS = 4000;
  localparam int          WAIT_UNIT_PS  = 640000;
  localparam int          UNIT_CYCLES   = (WAIT_UNIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage : eee_pkg
`default_nettype wire

// ===== logic/eee_port_control_indirect.sv
// Per-port EEE control/status registers behind an indirect byte window on APB
// How it works
// - Control byte select 001 plus port nibble 3 or 4 opens per-port EEE access.
// - Control/status register upper byte sits at offset 0x2C, lower at 0x2D.
// - Bit 15, reset 1, disables 10BASE-T EEE amplitude saving when set.
// - Bit 7 set lets hardware next-page exchange set bit 0 on match while bit 1 is clear.
// - Bit 7 clear means hardware never performs the capability exchange.
// - Bit 6 reads 1 while hardware negotiation has enabled 100BASE-TX EEE.
// - Bit 5 latches transmit idle signalling, cleared by reading the byte.
// - Bit 4 shows the live transmit idle indication.
// - Bit 3 latches receive idle signalling, cleared by reading the byte.
// - Bit 2 shows the live receive idle indication.
// - Bit 1 picks software (1) or hardware (0) as the EEE enable source.
// - Bit 0 enables 100BASE-TX EEE, written by software or set by hardware.
// - Recovery wait register upper byte at 0x2E, lower at 0x2F.
// - Recovery count resets to 0x27.
// - Read: write 0x30 style control, write offset to fetch, read data.
// - Write: write 0x20 style control, write offset, then write data.
// - Port nibble zero targets global registers, never a per-port one.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
module eee_port_control_indirect #(
  parameter int unsigned UNIT_CYCLES = eee_pkg::UNIT_CYCLES  // Cycles per 640 ns unit
) (
  input  wire logic        mclk_i,            // System clock, 250 MHz
  input  wire logic        rst_i,             // Async reset, active high
  input  wire logic        psel_i,            // APB select
  input  wire logic        penable_i,         // APB access phase
  input  wire logic        pwrite_i,          // APB write
  input  wire logic [11:0] paddr_i,           // APB byte address
  input  wire logic [31:0] pwdata_i,          // APB write data
  input  wire logic [3:0]  pstrb_i,           // APB byte strobes
  output logic      [31:0] prdata_o,          // APB read data
  output logic             pready_o,          // APB ready
  output logic             pslverr_o,         // APB error, unmapped address
  input  wire logic [1:0]  tx_idle_now_i,     // Transmit coding idle, per port
  input  wire logic [1:0]  rx_idle_now_i,     // Receive coding idle, per port
  input  wire logic [1:0]  np_match_i,        // Next-page exchange matched, pulse
  input  wire logic [1:0]  link_down_i,       // Link lost, per port
  output logic      [1:0]  ten_base_saving_off_o, // 10BASE-T saving disabled
  output logic      [1:0]  hw_capability_exchange_en_o, // Hardware exchange on
  output logic      [1:0]  fast_saving_o,     // 100BASE-TX EEE enabled
  output logic      [1:0]  tx_hold_o          // Transmit held after idle exit
);

  typedef struct packed {
    logic [7:0]       acc_ctrl;
    logic [7:0]       acc_offs;
    logic [7:0]       acc_data;
    logic             wr_armed;
    logic [1:0]       ten_base_saving_off;
    logic [1:0]       hw_capability_exchange_en;
    logic [1:0]       hw_negotiated_fast_saving;
    logic [1:0]       tx_idle_seen_sticky;
    logic [1:0]       rx_idle_seen_sticky;
    logic [1:0]       software_saving_select;
    logic [1:0]       fast_saving_enable;
    logic [1:0][7:0]  idle_wake_wait_count;
    logic [1:0]       tx_prev;
    logic [1:0]       waiting;
    logic [1:0][15:0] pre;
    logic [1:0][7:0]  units;
  } state_type;

  state_type q;
  state_type d;

  //////////////////////////////////////////////////////////////////////////////

  // Port nibble to port index; bit 1 flags a valid per-port target
  function automatic logic [1:0] port_decode(input logic [7:0] ctrl);
    logic [1:0] r;
    r = 2'b00;
    if (ctrl[eee_pkg::SEL_MSB:eee_pkg::SEL_LSB] == eee_pkg::SEL_EEE)
    begin
      if (ctrl[3:0] == eee_pkg::PORT_FIRST)
        r = 2'b10;
      else if (ctrl[3:0] == eee_pkg::PORT_SECOND)
        r = 2'b11;
    end
    return r;
  endfunction : port_decode

  // Byte image of a per-port register byte
  function automatic logic [7:0] reg_byte(input state_type s, input logic p,
                                          input logic [7:0] ofs, input logic txn,
                                          input logic rxn);
    logic [7:0] b;
    b = 8'h00;
    case (ofs)
      eee_pkg::OFS_CTL_HI:
        b[eee_pkg::POS_TEN_OFF] = s.ten_base_saving_off[p];
      eee_pkg::OFS_CTL_LO:
      begin
        b[eee_pkg::POS_HW_EXCH]   = s.hw_capability_exchange_en[p];
        b[eee_pkg::POS_HW_FAST]   = s.hw_negotiated_fast_saving[p];
        b[eee_pkg::POS_TX_STICKY] = s.tx_idle_seen_sticky[p];
        b[eee_pkg::POS_TX_NOW]    = txn;
        b[eee_pkg::POS_RX_STICKY] = s.rx_idle_seen_sticky[p];
        b[eee_pkg::POS_RX_NOW]    = rxn;
        b[eee_pkg::POS_SW_SEL]    = s.software_saving_select[p];
        b[eee_pkg::POS_FAST_EN]   = s.fast_saving_enable[p];
      end
      eee_pkg::OFS_WAIT_LO:
        b = s.idle_wake_wait_count[p];
      default:
        b = 8'h00;
    endcase
    return b;
  endfunction : reg_byte

  //////////////////////////////////////////////////////////////////////////////

  logic       acc_wr;
  logic       acc_rd;
  logic       hit_ctrl;
  logic       hit_offs;
  logic       hit_data;
  logic [1:0] port_sel;
  logic       is_read;
  logic       fetch_go;
  logic       apply_go;

  // Zero wait states; the word index is the address with the lane bits dropped
  assign pready_o  = 1'b1;
  assign acc_wr    = psel_i & penable_i & pwrite_i & pstrb_i[0];
  assign acc_rd    = psel_i & penable_i & ~pwrite_i;
  assign hit_ctrl  = (paddr_i == {2'b00, eee_pkg::IDX_ACC_CTRL, 2'b00});
  assign hit_offs  = (paddr_i == {2'b00, eee_pkg::IDX_ACC_OFFS, 2'b00});
  assign hit_data  = (paddr_i == {2'b00, eee_pkg::IDX_ACC_DATA, 2'b00});
  assign pslverr_o = psel_i & penable_i & ~(hit_ctrl | hit_offs | hit_data);
  assign port_sel  = port_decode(q.acc_ctrl);
  assign is_read   = q.acc_ctrl[eee_pkg::DIR_READ_BIT];
  // Offset write starts a read fetch; data write commits an armed write
  assign fetch_go  = acc_wr & hit_offs & is_read;
  assign apply_go  = acc_wr & hit_data & q.wr_armed & ~is_read & port_sel[1];

  always_comb
  begin
    prdata_o = 32'h0000_0000;
    if (hit_ctrl)
      prdata_o[7:0] = q.acc_ctrl;
    else if (hit_offs)
      prdata_o[7:0] = q.acc_offs;
    else if (hit_data)
      prdata_o[7:0] = q.acc_data;
  end

  //////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    d = q;

    if (acc_wr && hit_ctrl)
    begin
      d.acc_ctrl = pwdata_i[7:0];
      d.wr_armed = 1'b0;
    end

    if (acc_wr && hit_offs)
    begin
      d.acc_offs = pwdata_i[7:0];
      d.wr_armed = ~is_read;
      if (is_read)
      begin
        // Global or unknown targets belong elsewhere and read back as zero
        d.acc_data = 8'h00;
        if (port_sel[1])
        begin
          d.acc_data = reg_byte(q, port_sel[0], pwdata_i[7:0],
                                tx_idle_now_i[port_sel[0]],
                                rx_idle_now_i[port_sel[0]]);
          if (pwdata_i[7:0] == eee_pkg::OFS_CTL_LO)
          begin
            d.tx_idle_seen_sticky[port_sel[0]] = 1'b0;
            d.rx_idle_seen_sticky[port_sel[0]] = 1'b0;
          end
        end
      end
    end

    if (acc_wr && hit_data)
    begin
      d.acc_data = pwdata_i[7:0];
      if (apply_go)
      begin
        case (q.acc_offs)
          eee_pkg::OFS_CTL_HI:
            d.ten_base_saving_off[port_sel[0]] = pwdata_i[eee_pkg::POS_TEN_OFF];
          eee_pkg::OFS_CTL_LO:
          begin
            d.hw_capability_exchange_en[port_sel[0]] = pwdata_i[eee_pkg::POS_HW_EXCH];
            d.software_saving_select[port_sel[0]]    = pwdata_i[eee_pkg::POS_SW_SEL];
            d.fast_saving_enable[port_sel[0]]        = pwdata_i[eee_pkg::POS_FAST_EN];
          end
          eee_pkg::OFS_WAIT_LO:
            d.idle_wake_wait_count[port_sel[0]] = pwdata_i[7:0];
          default:
            d.wr_armed = q.wr_armed;
        endcase
      end
    end

    for (int p = 0; p < 2; p++)
    begin
      // Hardware sets come after the clears so a same-cycle event is kept
      if (tx_idle_now_i[p])
        d.tx_idle_seen_sticky[p] = 1'b1;
      if (rx_idle_now_i[p])
        d.rx_idle_seen_sticky[p] = 1'b1;

      if (link_down_i[p] || !q.hw_capability_exchange_en[p] ||
          q.software_saving_select[p])
        d.hw_negotiated_fast_saving[p] = 1'b0;
      if (q.hw_capability_exchange_en[p] && !q.software_saving_select[p] &&
          np_match_i[p])
      begin
        d.fast_saving_enable[p]        = 1'b1;
        d.hw_negotiated_fast_saving[p] = 1'b1;
      end

      // Recovery wait: count whole units once transmit idle ends
      d.tx_prev[p] = tx_idle_now_i[p];
      if (q.tx_prev[p] && !tx_idle_now_i[p])
      begin
        d.waiting[p] = (q.idle_wake_wait_count[p] != 8'h00);
        d.units[p]   = q.idle_wake_wait_count[p];
        d.pre[p]     = 16'h0000;
      end
      else if (q.waiting[p])
      begin
        if (tx_idle_now_i[p])
          d.waiting[p] = 1'b0;
        else if (q.pre[p] == 16'(UNIT_CYCLES - 1))
        begin
          d.pre[p]   = 16'h0000;
          d.units[p] = q.units[p] - 8'h01;
          if (q.units[p] == 8'h01)
            d.waiting[p] = 1'b0;
        end
        else
          d.pre[p] = q.pre[p] + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q                           <= '0;
      q.ten_base_saving_off       <= {2{eee_pkg::RST_TEN_OFF}};
      q.hw_capability_exchange_en <= {2{eee_pkg::RST_HW_EXCH}};
      q.software_saving_select    <= {2{eee_pkg::RST_SW_SEL}};
      q.fast_saving_enable        <= {2{eee_pkg::RST_FAST_EN}};
      q.idle_wake_wait_count      <= {2{eee_pkg::RST_WAIT_CNT}};
    end
    else
      q <= d;
  end

  assign ten_base_saving_off_o       = q.ten_base_saving_off;
  assign hw_capability_exchange_en_o = q.hw_capability_exchange_en;
  assign fast_saving_o               = q.fast_saving_enable;
  assign tx_hold_o                   = q.waiting;

  //////////////////////////////////////////////////////////////////////////////

  // Length of the current hold on the first port, read only by the checks
  logic [23:0] hold_run;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      hold_run <= 24'h000000;
    else if (q.waiting[0])
      hold_run <= hold_run + 24'h000001;
    else
      hold_run <= 24'h000000;
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  tx_sticky_set_a: assert property (tx_idle_now_i[0] |=> q.tx_idle_seen_sticky[0])
    else $error("transmit idle event lost");

  rx_sticky_clr_a: assert property (fetch_go && port_sel == 2'b10 &&
    pwdata_i[7:0] == eee_pkg::OFS_CTL_LO && !rx_idle_now_i[0]
    |=> !q.rx_idle_seen_sticky[0])
    else $error("receive idle flag not cleared by read");

  live_tx_read_a: assert property (fetch_go && port_sel == 2'b10 &&
    pwdata_i[7:0] == eee_pkg::OFS_CTL_LO
    |=> q.acc_data[eee_pkg::POS_TX_NOW] == $past(tx_idle_now_i[0]))
    else $error("live transmit idle bit wrong");

  hw_match_set_a: assert property (q.hw_capability_exchange_en[0] &&
    !q.software_saving_select[0] && np_match_i[0]
    |=> q.fast_saving_enable[0] && q.hw_negotiated_fast_saving[0])
    else $error("capability match did not enable saving");

  hw_exch_off_a: assert property (!q.hw_capability_exchange_en[0] && !apply_go
    && !q.fast_saving_enable[0] |=> !q.fast_saving_enable[0] &&
    !q.hw_negotiated_fast_saving[0])
    else $error("hardware enabled saving with exchange off");

  ten_off_write_a: assert property (apply_go && port_sel == 2'b10 &&
    q.acc_offs == eee_pkg::OFS_CTL_HI
    |=> q.ten_base_saving_off[0] == $past(pwdata_i[eee_pkg::POS_TEN_OFF]))
    else $error("10BASE-T saving control not written");

  global_untouched_a: assert property (acc_wr && hit_data &&
    q.acc_ctrl[3:0] == eee_pkg::PORT_GLOBAL
    |=> $stable(q.idle_wake_wait_count))
    else $error("global access changed a port register");

  hold_length_a: assert property ($fell(q.waiting[0]) && !$past(tx_idle_now_i[0])
    |-> hold_run == 24'(q.idle_wake_wait_count[0]) * 24'(UNIT_CYCLES))
    else $error("recovery hold length wrong");

  unmapped_err_a: assert property (psel_i && penable_i &&
    paddr_i == 12'h000 |-> pslverr_o)
    else $error("unmapped address not flagged");

  read_no_arm_a: assert property (acc_wr && hit_offs && is_read
    |=> !q.wr_armed)
    else $error("read access armed a write");

  rx_sticky_set_a: assert property (rx_idle_now_i[1] |=> q.rx_idle_seen_sticky[1])
    else $error("receive idle event lost");

  tx_sticky_clr_a: assert property (fetch_go && port_sel == 2'b11 &&
    pwdata_i[7:0] == eee_pkg::OFS_CTL_LO && !tx_idle_now_i[1]
    |=> !q.tx_idle_seen_sticky[1])
    else $error("transmit idle flag not cleared by read");

  live_rx_read_a: assert property (fetch_go && port_sel == 2'b10 &&
    pwdata_i[7:0] == eee_pkg::OFS_CTL_LO
    |=> q.acc_data[eee_pkg::POS_RX_NOW] == $past(rx_idle_now_i[0]))
    else $error("live receive idle bit wrong");

  wait_write_a: assert property (apply_go && port_sel == 2'b10 &&
    q.acc_offs == eee_pkg::OFS_WAIT_LO
    |=> q.idle_wake_wait_count[0] == $past(pwdata_i[7:0]))
    else $error("recovery count not written");

  sw_sel_hold_a: assert property (q.software_saving_select[1]
    |=> !q.hw_negotiated_fast_saving[1])
    else $error("hardware status set in software mode");

  link_drop_a: assert property (link_down_i[0] |=> !q.hw_negotiated_fast_saving[0])
    else $error("hardware status kept after link loss");

  wait_start_a: assert property ($fell(tx_idle_now_i[0]) &&
    q.idle_wake_wait_count[0] != 8'h00 |=> q.waiting[0])
    else $error("recovery hold did not start");

  global_read_zero_a: assert property (fetch_go && !port_sel[1]
    |=> q.acc_data == 8'h00)
    else $error("global fetch returned a port byte");

  fast_sw_write_a: assert property (apply_go && port_sel == 2'b11 &&
    q.acc_offs == eee_pkg::OFS_CTL_LO && !np_match_i[1]
    |=> q.fast_saving_enable[1] == $past(pwdata_i[eee_pkg::POS_FAST_EN]))
    else $error("software saving enable not written");

  read_data_zero_a: assert property (acc_rd && pslverr_o |-> prdata_o == 32'h0000_0000)
    else $error("unmapped read returned data");

endmodule : eee_port_control_indirect
`default_nettype wire

// ===== testbench/apb_host_model.sv
// APB host model: one setup plus access transfer for each start request
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  input  wire logic        mclk_i,    // Clock
  input  wire logic        rst_i,     // Reset, active high
  input  wire logic        start_i,   // Begin a transfer
  input  wire logic        wr_i,      // Direction, 1 writes
  input  wire logic [11:0] addr_i,    // Byte address
  input  wire logic [31:0] wdata_i,   // Write data
  input  wire logic [3:0]  strb_i,    // Byte strobes
  input  wire logic        pready_i,  // Slave ready
  input  wire logic [31:0] prdata_i,  // Slave read data
  input  wire logic        pslverr_i, // Slave error
  output logic             psel_o,    // Select
  output logic             penable_o, // Access phase
  output logic             pwrite_o,  // Write
  output logic      [11:0] paddr_o,   // Address
  output logic      [31:0] pwdata_o,  // Write data
  output logic      [3:0]  pstrb_o,   // Strobes
  output logic             done_o,    // Transfer over, one cycle
  output logic      [31:0] rdata_o,   // Read data taken at ready
  output logic             err_o      // Error taken at ready
);
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
      pwrite_o  <= 1'b0;
      paddr_o   <= 12'h000;
      pwdata_o  <= 32'h0000_0000;
      pstrb_o   <= 4'h0;
      done_o    <= 1'b0;
      rdata_o   <= 32'h0000_0000;
      err_o     <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (!psel_o && start_i)
      begin
        psel_o   <= 1'b1;
        pwrite_o <= wr_i;
        paddr_o  <= addr_i;
        pwdata_o <= wdata_i;
        pstrb_o  <= strb_i;
      end
      else if (psel_o && !penable_o)
        penable_o <= 1'b1;
      else if (penable_o && pready_i)
      begin
        // Released address and write data flip so a stale value never passes for a request
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
        paddr_o   <= ~paddr_o;
        pwdata_o  <= ~pwdata_o;
        done_o    <= 1'b1;
        rdata_o   <= prdata_i;
        err_o     <= pslverr_i;
      end
    end
  end
endmodule : apb_host_model
`default_nettype wire

// ===== testbench/test_eee_port_control_indirect.sv
// Self-checking bench for the indirect EEE port register block
`timescale 1ns/1ps
`default_nettype none
module test_eee_port_control_indirect;
  localparam int          UNITS  = 4;
  localparam logic [11:0] A_CTRL = {2'b00, eee_pkg::IDX_ACC_CTRL, 2'b00};
  localparam logic [11:0] A_OFFS = {2'b00, eee_pkg::IDX_ACC_OFFS, 2'b00};
  localparam logic [11:0] A_DATA = {2'b00, eee_pkg::IDX_ACC_DATA, 2'b00};
  typedef struct packed {logic [7:0] ctrl; logic [7:0] ofs; logic [7:0] exp;} row_type;
  row_type rows [10] = '{'{8'h33, 8'h2C, 8'h80}, '{8'h33, 8'h2D, 8'h80},
    '{8'h33, 8'h2E, 8'h00}, '{8'h33, 8'h2F, 8'h27}, '{8'h34, 8'h2C, 8'h80},
    '{8'h34, 8'h2D, 8'h80}, '{8'h34, 8'h2F, 8'h27}, '{8'h30, 8'h2F, 8'h00},
    '{8'h35, 8'h2F, 8'h00}, '{8'h53, 8'h2F, 8'h00}};
  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  logic        start  = 1'b0;
  logic        wr     = 1'b0;
  logic [11:0] addr   = 12'h000;
  logic [31:0] wdata  = 32'h0000_0000;
  logic [3:0]  strb   = 4'h0;
  logic [1:0]  tx_idle = 2'h0;
  logic [1:0]  rx_idle = 2'h0;
  logic [1:0]  np      = 2'h0;
  logic [1:0]  ld      = 2'h0;
  logic        psel, penable, pwrite, pready, pslverr, done, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, r;
  logic [3:0]  pstrb;
  logic [1:0]  ten_off, hw_exch, fast, hold;
  logic [7:0]  v;
  int          err_total = 0;
  int          n_checks  = 0;
  int          cnt;
  always #2 mclk_i = ~mclk_i;
  apb_host_model host (.mclk_i(mclk_i), .rst_i(rst_i), .start_i(start), .wr_i(wr),
    .addr_i(addr), .wdata_i(wdata), .strb_i(strb), .pready_i(pready), .prdata_i(prdata),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb), .done_o(done), .rdata_o(rdata),
    .err_o(err));
  eee_port_control_indirect #(.UNIT_CYCLES(UNITS)) DUT (.mclk_i(mclk_i), .rst_i(rst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .tx_idle_now_i(tx_idle), .rx_idle_now_i(rx_idle),
    .np_match_i(np), .link_down_i(ld), .ten_base_saving_off_o(ten_off),
    .hw_capability_exchange_en_o(hw_exch), .fast_saving_o(fast), .tx_hold_o(hold));
  //////////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("Counts: %0d errors in %0d checks", err_total, n_checks);
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task chk_b(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error at %0t: byte %h, expected %h", $time, g, e);
    end
  endtask : chk_b
  task chk_v(input logic [1:0] g, input logic [1:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error at %0t: port pair %b, expected %b", $time, g, e);
    end
  endtask : chk_v
  task chk_c(input int g, input int e);
    n_checks++;
    if (g != e)
    begin
      err_total++;
      $display("Error at %0t: hold %0d cycles, expected %0d", $time, g, e);
    end
  endtask : chk_c
  // The bus task never assumes a bus latency; only its bounded loop ends the wait
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge mclk_i);
    start <= 1'b1;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    strb  <= s;
    @(posedge mclk_i);
    start <= 1'b0;
    for (k = 0; k < 20 && done !== 1'b1; k++)
    begin
      @(posedge mclk_i);
      #1;
    end
    if (done !== 1'b1)
    begin
      err_total++;
      $display("Error at %0t: no bus answer", $time);
    end
    r = rdata;
  endtask : apb
  task ind_wr(input logic [7:0] c, input logic [7:0] o, input logic [7:0] d);
    apb(1'b1, A_CTRL, {24'h000000, c}, 4'hF);
    apb(1'b1, A_OFFS, {24'h000000, o}, 4'hF);
    apb(1'b1, A_DATA, {24'h000000, d}, 4'hF);
  endtask : ind_wr
  task ind_rd(input logic [7:0] c, input logic [7:0] o);
    apb(1'b1, A_CTRL, {24'h000000, c}, 4'hF);
    apb(1'b1, A_OFFS, {24'h000000, o}, 4'hF);
    apb(1'b0, A_DATA, 32'h0000_0000, 4'h0);
    v = r[7:0];
  endtask : ind_rd
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #40000;
    err_total++;
    test_done();
  end
  initial
  begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1;
    chk_v(ten_off, 2'b11);
    chk_v(hw_exch, 2'b11);
    chk_v(fast, 2'b00);
    chk_v(hold, 2'b00);
    foreach (rows[i])
    begin
      ind_rd(rows[i].ctrl, rows[i].ofs);
      chk_b(v, rows[i].exp);
    end
    apb(1'b0, 12'h000, 32'h0000_0000, 4'h0);
    chk_v({1'b0, err}, 2'b01);
    chk_b(r[7:0], 8'h00);
    ind_wr(8'h23, 8'h2C, 8'h00);
    chk_v(ten_off, 2'b10);
    ind_rd(8'h33, 8'h2C);
    chk_b(v, 8'h00);
    ind_wr(8'h24, 8'h2D, 8'h02);
    chk_v(hw_exch, 2'b01);
    chk_v(fast, 2'b00);
    ind_wr(8'h24, 8'h2E, 8'h55);
    ind_rd(8'h34, 8'h2E);
    chk_b(v, 8'h00);
    ind_wr(8'h20, 8'h2F, 8'h11);
    apb(1'b1, A_CTRL, 32'h0000_0023, 4'hF);
    apb(1'b1, A_OFFS, 32'h0000_002F, 4'hF);
    apb(1'b1, A_DATA, 32'h0000_0005, 4'hE);
    ind_rd(8'h33, 8'h2F);
    chk_b(v, eee_pkg::RST_WAIT_CNT);
    ind_wr(8'h23, 8'h2F, 8'h05);
    ind_rd(8'h33, 8'h2F);
    chk_b(v, 8'h05);
    @(posedge mclk_i);
    tx_idle <= 2'b01;
    rx_idle <= 2'b01;
    ind_rd(8'h33, 8'h2D);
    chk_b(v, 8'hBC);
    @(posedge mclk_i);
    tx_idle <= 2'b00;
    rx_idle <= 2'b00;
    cnt = 0;
    for (int k = 0; k < 200 && (cnt == 0 || hold[0] === 1'b1); k++)
    begin
      @(posedge mclk_i);
      #1;
      if (hold[0] === 1'b1)
        cnt++;
    end
    chk_c(cnt, 5 * UNITS);
    ind_rd(8'h33, 8'h2D);
    chk_b(v, 8'hA8);
    ind_rd(8'h33, 8'h2D);
    chk_b(v, 8'h80);
    @(posedge mclk_i);
    np <= 2'b11;
    @(posedge mclk_i);
    np <= 2'b00;
    @(posedge mclk_i);
    #1;
    chk_v(fast, 2'b01);
    ind_rd(8'h33, 8'h2D);
    chk_b(v, 8'hC1);
    @(posedge mclk_i);
    ld <= 2'b01;
    @(posedge mclk_i);
    ld <= 2'b00;
    ind_rd(8'h33, 8'h2D);
    chk_b(v & 8'h40, 8'h00);
    ind_wr(8'h24, 8'h2D, 8'h03);
    chk_v(fast, 2'b11);
    test_done();
  end
endmodule : test_eee_port_control_indirect
`default_nettype wire
